// File: design/scanner_io_consts.svh
// register offsets, field positions, reset values, clock and baud rates for the i/o mode logic
`ifndef SCANNER_IO_CONSTS_SVH
`define SCANNER_IO_CONSTS_SVH

// ==================== register offsets ====================
`define OFS_CFG       12'h000
`define OFS_ENC_STEP  12'h004
`define OFS_RESULT    12'h008
`define OFS_ANALOG    12'h00C
`define OFS_STATUS    12'h010
`define OFS_COUNT     12'h014
`define OFS_STAMP     12'h018

// ==================== cfg fields ====================
`define CFG_MODE_LSB   0
`define CFG_TRIG_LSB   4
`define CFG_SRC_BIT    7
`define CFG_ENC_BIT    8
`define CFG_ROLE_LSB   9
`define CFG_BAUD_LSB   11
`define CFG_NOTERM_BIT 14
`define CFG_INV_BIT    15
`define CFG_DFLT_LSB   16
`define CFG_HOLD_BIT   18
`define CFG_PTRIG_BIT  19
`define CFG_RESET      32'h0000_0000
`define ENC_STEP_RESET 16'h0001

// ==================== result / analog fields ====================
`define RES_OK_LSB     0
`define RES_NONE_LSB   8
`define ANA_ERR_BIT    16
`define ANA_MIN        16'h0000

// ==================== timing ====================
`define CLK_HZ         25000000
`define BAUD_9600      9600
`define BAUD_19200     19200
`define BAUD_38400     38400
`define BAUD_57600     57600
`define BAUD_115200    115200

`endif

// File: design/scanner_io_pkg.sv
// types shared by the scanner i/o mode logic
package scanner_io_pkg;

	// digital input modes
	typedef enum logic [3:0] {
		MODE_ENC_RESET     = 4'b0000,
		MODE_ENC_TRIG      = 4'b0001,
		MODE_TRIGGER       = 4'b0010,
		MODE_USER_TRIG     = 4'b0011,
		MODE_USER          = 4'b0100,
		MODE_TIMESTAMP     = 4'b0101,
		MODE_ENC_CONTAINER = 4'b0110,
		MODE_ENCA_CONTAINER = 4'b0111,
		MODE_GATED_ENC     = 4'b1000
	} in_mode_e;

	// differential port roles
	typedef enum logic [1:0] {
		ROLE_SERIAL   = 2'b00,
		ROLE_TRIG_IN  = 2'b01,
		ROLE_TRIG_OUT = 2'b10,
		ROLE_PROG_OUT = 2'b11
	} port_role_e;

	// trigger modes
	typedef enum logic [2:0] {
		TRIG_INTERNAL = 3'b000,
		TRIG_POS_EDGE = 3'b001,
		TRIG_NEG_EDGE = 3'b010,
		TRIG_POS_PULSE = 3'b011,
		TRIG_NEG_PULSE = 3'b100,
		TRIG_POS_GATE = 3'b101,
		TRIG_NEG_GATE = 3'b110,
		TRIG_ENCODER  = 3'b111
	} trig_mode_e;

	// digital out default for criteria set to none
	typedef enum logic [1:0] {
		DFLT_OK   = 2'b00,
		DFLT_NOK  = 2'b01,
		DFLT_KEEP = 2'b10
	} dout_dflt_e;

endpackage

// File: design/scanner_io_mode_logic.sv
// digital input mode, port role and output behaviour logic of the profile scanner
`timescale 1ns/100ps
`include "scanner_io_consts.svh"
`default_nettype none

module scanner_io_mode_logic #(
	parameter int NUM_OUT = 8,
	parameter int CNT_W   = 32
) (
	// clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// apb slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// digital inputs 1..4 on bits 0..3
	input  wire logic [3:0]         dig_in,
	// measurement core
	input  wire logic               internal_tick,
	input  wire logic               meas_done,
	output logic                    meas_start,
	output logic                    expose_gate,
	output logic                    container_trig,
	output logic [2:0]              user_mode,
	output logic                    user_mode_load,
	// differential port
	input  wire logic               port_in,
	output logic                    port_out,
	output logic                    port_oe,
	output logic                    term_en,
	input  wire logic               ser_txd,
	output logic                    ser_rxd,
	output logic                    baud_tick,
	// result outputs
	output logic [NUM_OUT-1:0]      dig_out,
	output logic [15:0]             analog_out
);

	// ==================== apb register file ====================
	logic [31:0]        cfg_ff, nxt_cfg;
	logic [15:0]        step_n_ff, nxt_step_n;
	logic [NUM_OUT-1:0] res_ok_ff, nxt_res_ok;
	logic [NUM_OUT-1:0] res_none_ff, nxt_res_none;
	logic               res_upd_ff, nxt_res_upd;
	logic [15:0]        ana_val_ff, nxt_ana_val;
	logic               ana_err_ff, nxt_ana_err;
	logic               ana_upd_ff, nxt_ana_upd;
	logic [31:0]        prdata_ff, nxt_prdata;
	logic               slverr_ff, nxt_slverr;
	logic               mapped;
	logic               wr_acc;

	// state read back by software
	logic [CNT_W-1:0]   count_ff;
	logic [3:0]         stamp_ff;
	logic [3:0]         mode_ff;
	logic [1:0]         role_ff;
	logic               busy_ff;
	logic [3:0]         in_s;

	assign pready  = 1'b1;
	assign prdata  = prdata_ff;
	assign pslverr = slverr_ff;
	assign wr_acc  = psel && penable && pwrite && mapped;

	always_comb begin
		mapped = (paddr == `OFS_CFG) || (paddr == `OFS_ENC_STEP) || (paddr == `OFS_RESULT) ||
			(paddr == `OFS_ANALOG) || (paddr == `OFS_STATUS) || (paddr == `OFS_COUNT) ||
			(paddr == `OFS_STAMP);
		nxt_cfg      = cfg_ff;
		nxt_step_n   = step_n_ff;
		nxt_res_ok   = res_ok_ff;
		nxt_res_none = res_none_ff;
		nxt_res_upd  = 1'b0;
		nxt_ana_val  = ana_val_ff;
		nxt_ana_err  = ana_err_ff;
		nxt_ana_upd  = 1'b0;
		nxt_prdata   = prdata_ff;
		nxt_slverr   = 1'b0;
		if (psel && !penable) begin
			nxt_slverr = !mapped;
			case (paddr)
				`OFS_CFG:      nxt_prdata = cfg_ff;
				`OFS_ENC_STEP: nxt_prdata = {16'h0000, step_n_ff};
				`OFS_STATUS:   nxt_prdata = {16'h0000, 2'b00, busy_ff, role_ff, 3'b000,
					mode_ff, in_s};
				`OFS_COUNT:    nxt_prdata = 32'(count_ff);
				`OFS_STAMP:    nxt_prdata = {28'h000_0000, stamp_ff};
				default:       nxt_prdata = 32'h0000_0000;
			endcase
		end
		if (wr_acc) begin
			case (paddr)
				`OFS_CFG:      nxt_cfg = pwdata;
				`OFS_ENC_STEP: nxt_step_n = pwdata[15:0];
				`OFS_RESULT: begin
					nxt_res_ok   = pwdata[`RES_OK_LSB +: NUM_OUT];
					nxt_res_none = pwdata[`RES_NONE_LSB +: NUM_OUT];
					nxt_res_upd  = 1'b1;
				end
				`OFS_ANALOG: begin
					nxt_ana_val = pwdata[15:0];
					nxt_ana_err = pwdata[`ANA_ERR_BIT];
					nxt_ana_upd = 1'b1;
				end
				default: nxt_cfg = cfg_ff;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff      <= `CFG_RESET;
			step_n_ff   <= `ENC_STEP_RESET;
			res_ok_ff   <= '0;
			res_none_ff <= '0;
			res_upd_ff  <= 1'b0;
			ana_val_ff  <= `ANA_MIN;
			ana_err_ff  <= 1'b0;
			ana_upd_ff  <= 1'b0;
			prdata_ff   <= 32'h0000_0000;
			slverr_ff   <= 1'b0;
		end else begin
			cfg_ff      <= nxt_cfg;
			step_n_ff   <= nxt_step_n;
			res_ok_ff   <= nxt_res_ok;
			res_none_ff <= nxt_res_none;
			res_upd_ff  <= nxt_res_upd;
			ana_val_ff  <= nxt_ana_val;
			ana_err_ff  <= nxt_ana_err;
			ana_upd_ff  <= nxt_ana_upd;
			prdata_ff   <= nxt_prdata;
			slverr_ff   <= nxt_slverr;
		end
	end

	// ==================== input synchroniser and edges ====================
	logic [3:0] sync1_ff, sync2_ff, prev_ff;
	logic       port_s1_ff, port_s2_ff, port_prev_ff;
	assign in_s = sync2_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff     <= 4'h0;
			sync2_ff     <= 4'h0;
			prev_ff      <= 4'h0;
			// line idles high: no false edge or rx start bit after reset
			port_s1_ff   <= 1'b1;
			port_s2_ff   <= 1'b1;
			port_prev_ff <= 1'b1;
		end else begin
			sync1_ff     <= dig_in;
			sync2_ff     <= sync1_ff;
			prev_ff      <= sync2_ff;
			port_s1_ff   <= port_in;
			port_s2_ff   <= port_s1_ff;
			port_prev_ff <= port_s2_ff;
		end
	end

	// ==================== active configuration ====================
	logic [3:0] nxt_mode;
	logic [1:0] nxt_role;
	logic       nxt_busy;

	always_comb begin
		nxt_mode = mode_ff;
		nxt_role = role_ff;
		if (!busy_ff && !meas_start) begin
			nxt_mode = cfg_ff[`CFG_MODE_LSB +: 4];
			nxt_role = cfg_ff[`CFG_ROLE_LSB +: 2];
		end
		nxt_busy = busy_ff;
		if (meas_done)
			nxt_busy = 1'b0;
		if (meas_start)
			nxt_busy = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff <= 4'h0;
			role_ff <= 2'b00;
			busy_ff <= 1'b0;
		end else begin
			mode_ff <= nxt_mode;
			role_ff <= nxt_role;
			busy_ff <= nxt_busy;
		end
	end

	// ==================== encoder counter ====================
	logic             enc_on, quad, single, idx_rst;
	logic             a_chg, b_chg, step, up;
	logic [CNT_W-1:0] nxt_count;
	logic [15:0]      acc_ff, nxt_acc;
	logic             enc_trig_ff, nxt_enc_trig;

	always_comb begin
		enc_on = cfg_ff[`CFG_ENC_BIT];
		quad   = enc_on && (mode_ff == scanner_io_pkg::MODE_ENC_RESET ||
			mode_ff == scanner_io_pkg::MODE_ENC_TRIG || mode_ff == scanner_io_pkg::MODE_ENC_CONTAINER ||
			mode_ff == scanner_io_pkg::MODE_GATED_ENC);
		single  = enc_on && (mode_ff == scanner_io_pkg::MODE_ENCA_CONTAINER);
		idx_rst = (mode_ff == scanner_io_pkg::MODE_ENC_RESET) && in_s[0] && !prev_ff[0];
		a_chg   = in_s[1] ^ prev_ff[1];
		b_chg   = in_s[2] ^ prev_ff[2];
		step    = (quad && (a_chg ^ b_chg)) || (single && in_s[1] && !prev_ff[1]);
		up      = single || (in_s[1] ^ prev_ff[2]);
		nxt_count = count_ff;
		if (idx_rst)
			nxt_count = '0;
		else if (step)
			nxt_count = up ? count_ff + 1'b1 : count_ff - 1'b1;
		nxt_acc      = acc_ff;
		nxt_enc_trig = 1'b0;
		if (step) begin
			if (acc_ff + 16'h0001 >= step_n_ff) begin
				nxt_acc      = 16'h0000;
				nxt_enc_trig = 1'b1;
			end else begin
				nxt_acc = acc_ff + 16'h0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_ff    <= '0;
			acc_ff      <= 16'h0000;
			enc_trig_ff <= 1'b0;
		end else begin
			count_ff    <= nxt_count;
			acc_ff      <= nxt_acc;
			enc_trig_ff <= nxt_enc_trig;
		end
	end

	// ==================== trigger, user modes, timestamp ====================
	logic       in1_trig, src_lvl, src_prev, rise, fall, fire, gate_lvl;
	logic [2:0] nxt_user;
	logic [2:0] user_ff;
	logic       uload_ff, nxt_uload;
	logic [3:0] nxt_stamp;
	logic       cont_ff, nxt_cont;

	always_comb begin
		in1_trig = (mode_ff == scanner_io_pkg::MODE_ENC_TRIG) ||
			(mode_ff == scanner_io_pkg::MODE_TRIGGER) ||
			(mode_ff == scanner_io_pkg::MODE_USER_TRIG);
		if (cfg_ff[`CFG_SRC_BIT]) begin
			src_lvl  = in1_trig && in_s[0];
			src_prev = in1_trig && prev_ff[0];
		end else begin
			src_lvl  = (role_ff == scanner_io_pkg::ROLE_TRIG_IN) && port_s2_ff;
			src_prev = (role_ff == scanner_io_pkg::ROLE_TRIG_IN) && port_prev_ff;
		end
		rise     = src_lvl && !src_prev;
		fall     = !src_lvl && src_prev;
		gate_lvl = 1'b0;
		case (cfg_ff[`CFG_TRIG_LSB +: 3])
			scanner_io_pkg::TRIG_INTERNAL:  fire = internal_tick;
			scanner_io_pkg::TRIG_POS_EDGE:  fire = rise;
			scanner_io_pkg::TRIG_NEG_EDGE:  fire = fall;
			scanner_io_pkg::TRIG_POS_PULSE: begin
				fire     = rise;
				gate_lvl = src_lvl;
			end
			scanner_io_pkg::TRIG_NEG_PULSE: begin
				fire     = fall;
				gate_lvl = !src_lvl && busy_ff;
			end
			scanner_io_pkg::TRIG_POS_GATE:  fire = internal_tick && src_lvl;
			scanner_io_pkg::TRIG_NEG_GATE:  fire = internal_tick && !src_lvl;
			scanner_io_pkg::TRIG_ENCODER:   fire = enc_trig_ff;
			default:                        fire = 1'b0;
		endcase
		if (mode_ff == scanner_io_pkg::MODE_GATED_ENC)
			fire = enc_trig_ff && in_s[0];
		case (mode_ff)
			scanner_io_pkg::MODE_USER_TRIG: nxt_user = {1'b0, in_s[2:1]};
			scanner_io_pkg::MODE_USER:      nxt_user = in_s[2:0];
			default:                        nxt_user = user_ff;
		endcase
		nxt_uload = (nxt_user != user_ff);
		nxt_stamp = stamp_ff;
		if (fire)
			nxt_stamp = (mode_ff == scanner_io_pkg::MODE_TIMESTAMP) ? in_s : 4'h0;
		nxt_cont = ((mode_ff == scanner_io_pkg::MODE_ENC_CONTAINER) ||
			(mode_ff == scanner_io_pkg::MODE_ENCA_CONTAINER)) &&
			in_s[0] && !prev_ff[0];
	end

	assign meas_start     = fire;
	assign expose_gate    = gate_lvl || fire;
	assign user_mode      = user_ff;
	assign user_mode_load = uload_ff;
	assign container_trig = cont_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			user_ff  <= 3'b000;
			uload_ff <= 1'b0;
			stamp_ff <= 4'h0;
			cont_ff  <= 1'b0;
		end else begin
			user_ff  <= nxt_user;
			uload_ff <= nxt_uload;
			stamp_ff <= nxt_stamp;
			cont_ff  <= nxt_cont;
		end
	end

	// ==================== differential port ====================
	logic [15:0] baud_div, baud_cnt_ff, nxt_baud_cnt;
	logic        tick_ff, nxt_tick;
	logic        pout_ff, nxt_pout, poe_ff, nxt_poe, rxd_ff, nxt_rxd, term_ff, nxt_term;

	always_comb begin
		case (cfg_ff[`CFG_BAUD_LSB +: 3])
			3'd0:    baud_div = 16'(`CLK_HZ / `BAUD_9600);
			3'd1:    baud_div = 16'(`CLK_HZ / `BAUD_19200);
			3'd2:    baud_div = 16'(`CLK_HZ / `BAUD_38400);
			3'd3:    baud_div = 16'(`CLK_HZ / `BAUD_57600);
			default: baud_div = 16'(`CLK_HZ / `BAUD_115200);
		endcase
		nxt_tick     = 1'b0;
		nxt_baud_cnt = 16'h0000;
		if (role_ff == scanner_io_pkg::ROLE_SERIAL) begin
			if (baud_cnt_ff + 16'h0001 >= baud_div)
				nxt_tick = 1'b1;
			else
				nxt_baud_cnt = baud_cnt_ff + 16'h0001;
		end
		nxt_rxd = 1'b1;
		case (role_ff)
			scanner_io_pkg::ROLE_SERIAL: begin
				nxt_pout = ser_txd;
				nxt_poe  = 1'b1;
				nxt_rxd  = port_s2_ff;
			end
			scanner_io_pkg::ROLE_TRIG_IN: begin
				nxt_pout = 1'b0;
				nxt_poe  = 1'b0;
			end
			scanner_io_pkg::ROLE_TRIG_OUT: begin
				nxt_pout = busy_ff || fire;
				nxt_poe  = 1'b1;
			end
			default: begin
				nxt_pout = cfg_ff[`CFG_PTRIG_BIT];
				nxt_poe  = 1'b1;
			end
		endcase
		nxt_term = !cfg_ff[`CFG_NOTERM_BIT] && ((role_ff == scanner_io_pkg::ROLE_SERIAL) ||
			(role_ff == scanner_io_pkg::ROLE_TRIG_IN));
	end

	assign baud_tick = tick_ff;
	assign port_out  = pout_ff;
	assign port_oe   = poe_ff;
	assign ser_rxd   = rxd_ff;
	assign term_en   = term_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_cnt_ff <= 16'h0000;
			tick_ff     <= 1'b0;
			pout_ff     <= 1'b1;
			poe_ff      <= 1'b0;
			rxd_ff      <= 1'b1;
			term_ff     <= 1'b0;
		end else begin
			baud_cnt_ff <= nxt_baud_cnt;
			tick_ff     <= nxt_tick;
			pout_ff     <= nxt_pout;
			poe_ff      <= nxt_poe;
			rxd_ff      <= nxt_rxd;
			term_ff     <= nxt_term;
		end
	end

	// ==================== result outputs ====================
	logic [NUM_OUT-1:0] logic_ff, nxt_logic;
	logic [NUM_OUT-1:0] dout_ff, nxt_dout;
	logic [15:0]        aout_ff, nxt_aout;

	always_comb begin
		nxt_logic = logic_ff;
		if (res_upd_ff) begin
			for (int i = 0; i < NUM_OUT; i++) begin
				if (!res_none_ff[i])
					nxt_logic[i] = res_ok_ff[i];
				else if (cfg_ff[`CFG_DFLT_LSB +: 2] == scanner_io_pkg::DFLT_OK)
					nxt_logic[i] = 1'b1;
				else if (cfg_ff[`CFG_DFLT_LSB +: 2] == scanner_io_pkg::DFLT_NOK)
					nxt_logic[i] = 1'b0;
				else
					nxt_logic[i] = logic_ff[i];
			end
		end
		nxt_dout = cfg_ff[`CFG_INV_BIT] ? ~nxt_logic : nxt_logic;
		nxt_aout = aout_ff;
		if (ana_upd_ff)
			nxt_aout = !ana_err_ff ? ana_val_ff : (cfg_ff[`CFG_HOLD_BIT] ? aout_ff : `ANA_MIN);
	end

	assign dig_out    = dout_ff;
	assign analog_out = aout_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			logic_ff <= '0;
			dout_ff  <= '0;
			aout_ff  <= `ANA_MIN;
		end else begin
			logic_ff <= nxt_logic;
			dout_ff  <= nxt_dout;
			aout_ff  <= nxt_aout;
		end
	end

endmodule

`default_nettype wire

// File: dv/scanner_io_mode_logic_checker.sv
// port assertions for the scanner i/o mode logic
`timescale 1ns/100ps
`include "scanner_io_consts.svh"
`default_nettype none
module scanner_io_mode_logic_checker #(
	parameter int NUM_OUT = 8,
	parameter int CNT_W   = 32
) (
	// clock, reset and apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// measurement core, port and results
	input wire logic        meas_start,
	input wire logic        expose_gate,
	input wire logic        container_trig,
	input wire logic [2:0]  user_mode,
	input wire logic        user_mode_load,
	input wire logic        baud_tick,
	input wire logic [15:0] analog_out
);
	// ==================== helpers ====================
	wire logic        bad    = paddr > `OFS_STAMP || paddr[1:0] != 2'b00;
	wire logic        ana_wr = psel && penable && pwrite && paddr == `OFS_ANALOG;
	logic      [15:0] ana_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ana_ff <= 16'h0000;
		else if (ana_wr) ana_ff <= pwdata[15:0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==================== assertions ====================
	a_ready_high: assert property (pready)
		else $error("pready low");
	a_bad_addr_err: assert property (psel && !penable && bad |=> pslverr)
		else $error("no pslverr on unmapped address");
	a_good_addr_ok: assert property (psel && !penable && !bad |=> !pslverr)
		else $error("pslverr on mapped address");
	a_bad_read_zero: assert property (psel && penable && !pwrite && bad |-> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_analog_load: assert property (ana_wr && !pwdata[`ANA_ERR_BIT] |-> ##[1:3] analog_out == ana_ff)
		else $error("analog value not driven");
	a_baud_space: assert property (baud_tick |=> !baud_tick [*8])
		else $error("baud ticks too close");
	a_mode_load: assert property ($changed(user_mode) |-> user_mode_load)
		else $error("user mode change without load");
	a_load_cause: assert property (user_mode_load |-> user_mode != $past(user_mode))
		else $error("load without user mode change");
	a_start_gate: assert property (meas_start |-> expose_gate)
		else $error("start without exposure");
	a_cont_pulse: assert property (container_trig |=> !container_trig)
		else $error("container trigger too long");
endmodule
bind scanner_io_mode_logic scanner_io_mode_logic_checker #(.NUM_OUT(NUM_OUT), .CNT_W(CNT_W)) i_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.meas_start(meas_start), .expose_gate(expose_gate), .container_trig(container_trig),
	.user_mode(user_mode), .user_mode_load(user_mode_load), .baud_tick(baud_tick),
	.analog_out(analog_out)
);
`default_nettype wire

// File: dv/scanner_io_far_side.sv
// encoder and trigger source on the digital inputs and the port
`timescale 1ns/100ps
`default_nettype none
module scanner_io_far_side (
	// digital inputs and port receive line
	output logic [3:0] dig_in,
	output logic       port_in
);
	logic [1:0] ph;
	initial begin
		dig_in = 4'h0;
		port_in = 1'b1;
		ph = 2'b00;
	end
	// one quadrature transition, a leads b counting up
	task automatic step(input bit up);
		ph = up ? ph + 2'd1 : ph - 2'd1;
		dig_in[2:1] <= {ph[1], ph[1] ^ ph[0]};
	endtask
	// level on one digital input, one edge per wanted measurement
	task automatic lvl(input int b, input logic v);
		dig_in[b] <= v;
	endtask
	task automatic put(input logic [3:0] v);
		dig_in <= v;
		ph = {v[2], v[2] ^ v[1]};
	endtask
	// level on the port receive line, one edge per wanted measurement
	task automatic line(input logic v);
		port_in <= v;
	endtask
endmodule
`default_nettype wire

// File: dv/scanner_io_mode_logic_tb_top.sv
// self-checking bench for the scanner i/o mode logic
`timescale 1ns/100ps
`include "scanner_io_consts.svh"
`default_nettype none
module scanner_io_mode_logic_tb_top;
	// ==================== signals ====================
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, perr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic        pready, pslverr, internal_tick = 0, meas_done = 0, ser_txd = 1, port_in;
	logic        meas_start, expose_gate, container_trig, user_mode_load, port_out, port_oe;
	logic        term_en, ser_rxd, baud_tick;
	logic [3:0]  dig_in;
	logic [2:0]  user_mode;
	logic [7:0]  dig_out;
	logic [15:0] analog_out;
	int          mismatches = 0, samples_checked = 0, ncyc = 0, nst = 0, nct = 0, nbt = 0;
	int          bper = 0, blast = 0, seed = 59290, lg = 0, nex = 0, e, m;
	int          br[6] = '{`BAUD_9600, `BAUD_19200, `BAUD_38400, `BAUD_57600, `BAUD_115200,
		`BAUD_115200};
	bit          done_req;
	scanner_io_mode_logic i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dig_in(dig_in), .internal_tick(internal_tick), .meas_done(meas_done),
		.meas_start(meas_start), .expose_gate(expose_gate), .container_trig(container_trig),
		.user_mode(user_mode), .user_mode_load(user_mode_load), .port_in(port_in),
		.port_out(port_out), .port_oe(port_oe), .term_en(term_en), .ser_txd(ser_txd),
		.ser_rxd(ser_rxd), .baud_tick(baud_tick), .dig_out(dig_out), .analog_out(analog_out)
	);
	scanner_io_far_side i_far (.dig_in(dig_in), .port_in(port_in));
	// ==================== clock, core model, monitors ====================
	always #20 pclk = ~pclk;
	always @(posedge pclk) begin
		ncyc++;
		meas_done <= done_req;
		done_req = 0;
		ser_txd <= 1'($random(seed));
		if (ncyc == 60000) begin
			mismatches++;
			close_out;
		end
	end
	always @(negedge pclk) begin
		if (meas_start === 1'b1) begin
			nst++;
			done_req = 1;
		end
		if (container_trig === 1'b1) nct++;
		if (expose_gate === 1'b1) nex++;
		if (baud_tick === 1'b1) begin
			bper = ncyc - blast;
			blast = ncyc;
			nbt++;
		end
	end
	// ==================== tasks ====================
	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		samples_checked++;
		if (g !== x) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	function automatic logic [31:0] cf(input int md, input int t, input int r, input int b,
		input logic [31:0] x);
		return 32'(md) | 32'(t) << `CFG_TRIG_LSB | 32'(r) << `CFG_ROLE_LSB | 32'(b) << `CFG_BAUD_LSB | x;
	endfunction
	// ==================== sequence ====================
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `OFS_CFG, 0);
		chk(q, `CFG_RESET);
		apb(1'b0, `OFS_ENC_STEP, 0);
		chk(q, 32'(`ENC_STEP_RESET));
		apb(1'b0, 12'h020, 0);
		chk({q[31:1], perr}, 32'h0000_0001);
		for (int i = 0; i < 6; i++) begin
			e = $random(seed);
			wr(`OFS_CFG, cf(0, 0, 0, 0, 32'(i % 2) << `CFG_INV_BIT | 32'(i / 2) << `CFG_DFLT_LSB));
			wr(`OFS_RESULT, 32'(e));
			wt(3);
			for (int b = 0; b < 8; b++) lg[b] = !e[8 + b] ? e[b] : i / 2 == 2 ? lg[b] : i / 2 == 0;
			chk(32'(dig_out), 32'(lg[7:0] ^ {8{i % 2 == 1}}));
		end
		e = $random(seed);
		wr(`OFS_CFG, cf(0, 0, 0, 0, 1 << `CFG_HOLD_BIT));
		wr(`OFS_ANALOG, 32'(e[15:0]));
		wr(`OFS_ANALOG, 32'h0001_0000 | 32'($random(seed)) & 32'h0000_ffff);
		wt(3);
		chk(32'(analog_out), 32'(e[15:0]));
		wr(`OFS_CFG, 0);
		wr(`OFS_ANALOG, 32'h0001_1234);
		wt(3);
		chk(32'(analog_out), 32'(`ANA_MIN));
		for (int r = 0; r < 8; r++) begin
			wr(`OFS_CFG, cf(0, 0, r % 4, 0,
				32'(r / 4) << `CFG_NOTERM_BIT | 32'(r / 4) << `CFG_PTRIG_BIT));
			wt(4);
			chk(32'({term_en, port_oe}), 32'({r < 2, r % 4 != 1}));
			nbt = 0;
			wt(300);
			if (r % 4 != 0) chk(32'({ser_rxd, nbt != 0}), 32'h0000_0002);
			if (r % 4 != 0) chk(32'(port_out), 32'(r == 7));
		end
		for (int b = 0; b < 6; b++) begin
			wr(`OFS_CFG, cf(0, 0, 0, b, 0));
			nbt = 0;
			for (int n = 0; n < 9000 && nbt < 3; n++) @(posedge pclk);
			e = `CLK_HZ / br[b];
			chk(32'(bper >= e - 1 && bper <= e + 1), 1);
		end
		wr(`OFS_CFG, cf(0, 0, 0, 0, 1 << `CFG_ENC_BIT));
		apb(1'b0, `OFS_COUNT, 0);
		e = q;
		for (int s = 0; s < 9; s++) begin
			i_far.step(s < 6);
			wt(4);
		end
		apb(1'b0, `OFS_COUNT, 0);
		chk(q, 32'(e + 3));
		i_far.lvl(0, 1'b1);
		wt(5);
		apb(1'b0, `OFS_COUNT, 0);
		chk(q, 0);
		wr(`OFS_ENC_STEP, 3);
		for (int g = 0; g < 3; g++) begin
			m = g == 0 ? 1 : 8;
			i_far.lvl(0, g != 1);
			wr(`OFS_CFG, cf(m, 7, 0, 0, 1 << `CFG_ENC_BIT));
			nst = 0;
			repeat (6) begin
				i_far.step(1'b1);
				wt(4);
			end
			chk(nst, g == 1 ? 0 : g == 0 ? 2 : 6);
			wr(`OFS_ENC_STEP, 1);
		end
		for (int k = 6; k < 8; k++) begin
			wr(`OFS_CFG, cf(k, 0, 0, 0, 1 << `CFG_ENC_BIT));
			i_far.lvl(0, 1'b0);
			wt(5);
			nct = 0;
			i_far.lvl(0, 1'b1);
			wt(5);
			chk(nct, 1);
		end
		for (int k = 0; k < 8; k++) begin
			e = $random(seed);
			wr(`OFS_CFG, cf(3 + k % 2, 0, 0, 0, 0));
			i_far.put(4'(e));
			wt(5);
			chk(32'(user_mode), k % 2 ? 32'(e[2:0]) : 32'(e[2:1]));
			apb(1'b0, `OFS_STATUS, 0);
			chk(32'(q[7:0]), 32'({4'(3 + k % 2), 4'(e)}));
		end
		wr(`OFS_CFG, cf(5, 0, 0, 0, 0));
		e = $random(seed);
		i_far.put(4'(e));
		wt(4);
		internal_tick <= 1'b1;
		@(posedge pclk);
		internal_tick <= 1'b0;
		wt(4);
		apb(1'b0, `OFS_STAMP, 0);
		chk(32'(q[3:0]), 32'(e[3:0]));
		i_far.line(1'b0);
		wt(4);
		chk(32'(ser_rxd), 0);
		// port as trigger source in each edge, pulse and gate mode
		for (int t = 1; t < 7; t++) begin
			wr(`OFS_CFG, cf(2, t, 1, 0, 0));
			wt(6);
			nst = 0;
			nex = 0;
			i_far.line(1'b1);
			wt(8);
			i_far.line(1'b0);
			wt(8);
			chk(nst, t < 5);
			if (t < 4) chk(nex, t == 3 ? 8 : 1);
		end
		close_out;
	end
endmodule
`default_nettype wire
